//--- src/apm_pkg.sv
// Constants shared by the auxiliary port and mode pin block
package apm_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;        // System clock period
    localparam int CLK_FREQ_KHZ = 100000;     // System clock rate
    localparam int OSC_OUT_FREQ_KHZ = 7680;   // Oscillator clock output rate
    localparam int OSC_ACC_W = 17;            // Phase accumulator width
    // Two toggles per output period
    localparam logic [OSC_ACC_W-1:0] OSC_STEP = OSC_ACC_W'(2 * OSC_OUT_FREQ_KHZ);
    localparam logic [OSC_ACC_W-1:0] OSC_MOD = OSC_ACC_W'(CLK_FREQ_KHZ);
    localparam int RESET_PULSE_NS = 1000;     // Least low time of reset output
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 16;            // Reset pulse counter width
    localparam int STRAP_SETTLE_CYCLES = 5;   // Synchroniser fill before strap capture
    localparam int STRAP_CNT_W = 3;

    // ------------------------------------------------------------
    // Pin and field positions
    // ------------------------------------------------------------
    localparam int PIN_FOUR = 0;              // Index of aux pin four in pin vectors
    localparam int PIN_FIVE = 1;
    localparam int PIN_SIX = 2;
    localparam int PIN_SEVEN = 3;
    localparam int IRQ_SIX = 0;               // Index in interrupt vectors
    localparam int IRQ_SEVEN = 1;
    localparam int SYNC_W = 6;                // Four aux pins plus two straps
    localparam int SYNC_FIRST = 4;            // First mode strap in sync vector
    localparam int SYNC_SECOND = 5;           // Second mode strap / wake
    localparam logic SYNC_IDLE = 1'b1;        // Pulled-up pins idle high

    // ------------------------------------------------------------
    // Operating modes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        APM_MODE_TERM = 3'h1,                 // Terminal
        APM_MODE_LTT = 3'h2,                  // Line-terminal-T
        APM_MODE_LTS = 3'h4                   // Line-terminal-S
    } apm_mode_t;

endpackage

//--- src/apm_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps

// ------------------------------------------------------------
// Synchroniser
// ------------------------------------------------------------
module apm_sync3 #(
    parameter int WIDTH = 1,
    parameter logic IDLE = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] s1_r;                   // Metastable stage, read only by s2
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("apm_sync3 needs WIDTH of at least one");
        end
    endgenerate

    // Accept a new level only once stages two and three agree
    always_comb begin
        q_nxt = (s2_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));
    end

    // Stage registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= {WIDTH{IDLE}};
            s2_r <= {WIDTH{IDLE}};
            s3_r <= {WIDTH{IDLE}};
            q_r <= {WIDTH{IDLE}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

//--- src/apm_aux_mode.sv
// Upper auxiliary port pins, mode straps, wake, LED, clock and reset output
`timescale 1ns/10ps

module apm_aux_mode #(
    parameter int RESET_PULSE_CYCLES = apm_pkg::RESET_PULSE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] aux_pins_in,       // Pin levels, index 0 is pin four
    output logic [3:0] aux_pins_out,          // Open drain: always low when driven
    output logic [3:0] aux_pins_oe_n,         // Low pulls the pin low
    input wire logic [3:0] gpio_dir,          // 1 = output
    input wire logic [3:0] gpio_out_val,
    output logic [3:0] gpio_in_level,
    input wire logic multiframe_pin_select,
    input wire logic multiframe_bit_out,      // Bit to send in output role
    output logic multiframe_bit_in,           // Bit seen in input role
    input wire logic network_termination_mode,
    input wire logic clock_out_pin_select,
    input wire logic sync_or_bitclock_choice, // 1 = bit clock, 0 = frame sync
    input wire logic frame_sync,
    input wire logic bit_clock_out,
    input wire logic stop_go_bit_output_select,
    input wire logic stop_go_bit,             // From the downstream data line
    input wire logic [1:0] irq_enable,        // Index 0 pin six, 1 pin seven
    input wire logic [1:0] irq_edge_mode,     // 1 = falling edge, 0 = low level
    input wire logic [1:0] irq_clear,
    output logic [1:0] irq_status,
    output logic aux_irq_out,
    input wire logic first_mode_strap,
    input wire logic second_mode_strap,
    output logic mode_valid,
    output logic terminal_mode,
    output logic line_terminal_t_mode,
    output logic line_terminal_s_mode,
    input wire logic wake_reset_enable,
    input wire logic wake_clear,
    output logic wake_status,
    input wire logic led_auto_select,
    input wire logic led_sw_value,
    input wire logic line_activated,
    output logic activation_led_out,
    output logic oscillator_clock_out,
    input wire logic watchdog_timeout,
    input wire logic sw_reset_cmd,
    output logic reset_output_out,
    output logic reset_output_oe_n
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (RESET_PULSE_CYCLES < 1 || RESET_PULSE_CYCLES >= (1 << apm_pkg::RST_CNT_W)) begin : g_chk
            $error("RESET_PULSE_CYCLES out of counter range");
        end
    endgenerate

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [apm_pkg::SYNC_W-1:0] sync_q;       // Filtered pin levels
    logic wake_cur;                           // Second strap, synchronised
    logic [1:0] irq_pin;                      // Pins six and seven, synchronised

    // Straps and pins are asynchronous to clk
    apm_sync3 #(
        .WIDTH(apm_pkg::SYNC_W),
        .IDLE(apm_pkg::SYNC_IDLE)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({second_mode_strap, first_mode_strap, aux_pins_in}),
        .q(sync_q)
    );

    assign wake_cur = sync_q[apm_pkg::SYNC_SECOND];
    assign irq_pin = {sync_q[apm_pkg::PIN_SEVEN], sync_q[apm_pkg::PIN_SIX]};

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [apm_pkg::STRAP_CNT_W-1:0] strap_cnt_r, strap_cnt_nxt;
    logic mode_valid_r, mode_valid_nxt;
    apm_pkg::apm_mode_t mode_r, mode_nxt;
    logic [3:0] oe_n_r, oe_n_nxt;             // Pin drive, low = pull low
    logic [3:0] gpio_in_r, gpio_in_nxt;
    logic mf_in_r, mf_in_nxt;
    logic [1:0] irq_prev_r, irq_prev_nxt;     // Last level for edge detect
    logic [1:0] irq_stat_r, irq_stat_nxt;
    logic irq_out_r, irq_out_nxt;
    logic wake_prev_r, wake_prev_nxt;
    logic wake_stat_r, wake_stat_nxt;
    logic [apm_pkg::RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
    logic rst_oe_n_r, rst_oe_n_nxt;
    logic led_r, led_nxt;
    logic [apm_pkg::OSC_ACC_W-1:0] osc_acc_r, osc_acc_nxt;
    logic osc_r, osc_nxt;

    // Combinational helpers
    logic mf_output_role;                     // Multiframe pin drives
    logic [1:0] irq_in_role;                  // Pin acts as input
    logic [1:0] irq_event;
    logic wake_fall;
    logic [apm_pkg::OSC_ACC_W-1:0] osc_sum;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        // Mode straps captured once the synchroniser has filled
        strap_cnt_nxt = strap_cnt_r;
        mode_valid_nxt = mode_valid_r;
        mode_nxt = mode_r;
        if (!mode_valid_r) begin
            if (strap_cnt_r == apm_pkg::STRAP_CNT_W'(apm_pkg::STRAP_SETTLE_CYCLES - 1)) begin
                mode_valid_nxt = 1'b1;
                if (!sync_q[apm_pkg::SYNC_FIRST]) begin
                    mode_nxt = apm_pkg::APM_MODE_TERM;
                end else if (!sync_q[apm_pkg::SYNC_SECOND]) begin
                    mode_nxt = apm_pkg::APM_MODE_LTT;
                end else begin
                    mode_nxt = apm_pkg::APM_MODE_LTS;
                end
            end else begin
                strap_cnt_nxt = strap_cnt_r + 1'b1;
            end
        end

        // Multiframe bit drives in terminal and line-terminal-T only
        mf_output_role = !network_termination_mode &&
            (mode_r == apm_pkg::APM_MODE_TERM || mode_r == apm_pkg::APM_MODE_LTT);

        // Plain GPIO drive, then alternate roles override
        oe_n_nxt = ~(gpio_dir & ~gpio_out_val);
        if (multiframe_pin_select) begin
            // Input role simply releases the pin
            oe_n_nxt[apm_pkg::PIN_FOUR] = mf_output_role ? multiframe_bit_out : 1'b1;
        end
        if (clock_out_pin_select) begin
            oe_n_nxt[apm_pkg::PIN_FIVE] = sync_or_bitclock_choice ? bit_clock_out
                                                                  : frame_sync;
        end
        if (stop_go_bit_output_select) begin
            oe_n_nxt[apm_pkg::PIN_SEVEN] = stop_go_bit;
        end
        gpio_in_nxt = sync_q[3:0];
        mf_in_nxt = sync_q[apm_pkg::PIN_FOUR];

        // Aux interrupts: pins act as inputs unless driven or mirroring
        irq_in_role[apm_pkg::IRQ_SIX] = !gpio_dir[apm_pkg::PIN_SIX];
        irq_in_role[apm_pkg::IRQ_SEVEN] = !gpio_dir[apm_pkg::PIN_SEVEN] &&
                                          !stop_go_bit_output_select;
        // Edge: falling edge; level: low level keeps setting the flag
        irq_event = irq_in_role & ((irq_edge_mode & irq_prev_r & ~irq_pin) |
                                   (~irq_edge_mode & ~irq_pin));
        irq_prev_nxt = irq_pin;
        // Set wins over a simultaneous clear
        irq_stat_nxt = (irq_stat_r & ~irq_clear) | irq_event;
        irq_out_nxt = |(irq_stat_nxt & irq_enable);

        // External wake is only live in terminal mode
        wake_fall = mode_valid_r && mode_r == apm_pkg::APM_MODE_TERM &&
                    wake_prev_r && !wake_cur;
        wake_prev_nxt = wake_cur;
        wake_stat_nxt = (wake_stat_r & ~wake_clear) | wake_fall;

        // Reset pulse restarts on every trigger
        if (watchdog_timeout || sw_reset_cmd || (wake_fall && wake_reset_enable)) begin
            rst_cnt_nxt = apm_pkg::RST_CNT_W'(RESET_PULSE_CYCLES);
        end else if (rst_cnt_r != '0) begin
            rst_cnt_nxt = rst_cnt_r - 1'b1;
        end else begin
            rst_cnt_nxt = rst_cnt_r;
        end
        rst_oe_n_nxt = (rst_cnt_nxt == '0);

        // Activated state shows as a low level
        led_nxt = led_auto_select ? !line_activated : led_sw_value;

        // Fractional divider: toggles average 15.36 MHz, jitter one cycle
        osc_sum = osc_acc_r + apm_pkg::OSC_STEP;
        if (osc_sum >= apm_pkg::OSC_MOD) begin
            osc_acc_nxt = osc_sum - apm_pkg::OSC_MOD;
            osc_nxt = !osc_r;
        end else begin
            osc_acc_nxt = osc_sum;
            osc_nxt = osc_r;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_r <= '0;
            mode_valid_r <= 1'b0;
            mode_r <= apm_pkg::APM_MODE_TERM;
            oe_n_r <= 4'hF;
            gpio_in_r <= 4'hF;
            mf_in_r <= 1'b1;
            irq_prev_r <= 2'h3;
            irq_stat_r <= 2'h0;
            irq_out_r <= 1'b0;
            wake_prev_r <= 1'b1;
            wake_stat_r <= 1'b0;
            rst_cnt_r <= '0;
            rst_oe_n_r <= 1'b1;
            led_r <= 1'b1;
            osc_acc_r <= '0;
            osc_r <= 1'b0;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            mode_valid_r <= mode_valid_nxt;
            mode_r <= mode_nxt;
            oe_n_r <= oe_n_nxt;
            gpio_in_r <= gpio_in_nxt;
            mf_in_r <= mf_in_nxt;
            irq_prev_r <= irq_prev_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_out_r <= irq_out_nxt;
            wake_prev_r <= wake_prev_nxt;
            wake_stat_r <= wake_stat_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            rst_oe_n_r <= rst_oe_n_nxt;
            led_r <= led_nxt;
            osc_acc_r <= osc_acc_nxt;
            osc_r <= osc_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign aux_pins_out = 4'h0;
    assign aux_pins_oe_n = oe_n_r;
    assign gpio_in_level = gpio_in_r;
    assign multiframe_bit_in = mf_in_r;
    assign irq_status = irq_stat_r;
    assign aux_irq_out = irq_out_r;
    assign mode_valid = mode_valid_r;
    assign terminal_mode = mode_valid_r && mode_r == apm_pkg::APM_MODE_TERM;
    assign line_terminal_t_mode = mode_valid_r && mode_r == apm_pkg::APM_MODE_LTT;
    assign line_terminal_s_mode = mode_valid_r && mode_r == apm_pkg::APM_MODE_LTS;
    assign wake_status = wake_stat_r;
    assign activation_led_out = led_r;
    assign oscillator_clock_out = osc_r;
    assign reset_output_out = 1'b0;
    assign reset_output_oe_n = rst_oe_n_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_GPIO_SIX: assert property (@(posedge clk) disable iff (!rst_n)
        (gpio_dir[apm_pkg::PIN_SIX] && !gpio_out_val[apm_pkg::PIN_SIX])
        |=> !aux_pins_oe_n[apm_pkg::PIN_SIX])
        else $error("pin six not driven low as gpio output");

    AST_MF_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        (multiframe_pin_select && mf_output_role)
        |=> aux_pins_oe_n[apm_pkg::PIN_FOUR] == $past(multiframe_bit_out))
        else $error("multiframe bit not on pin four");

    AST_CLK_FIVE: assert property (@(posedge clk) disable iff (!rst_n)
        clock_out_pin_select |=> aux_pins_oe_n[apm_pkg::PIN_FIVE] ==
        ($past(sync_or_bitclock_choice) ? $past(bit_clock_out) : $past(frame_sync)))
        else $error("pin five does not follow chosen clock");

    AST_IRQ_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_in_role[apm_pkg::IRQ_SIX] && irq_edge_mode[apm_pkg::IRQ_SIX] &&
         $fell(irq_pin[apm_pkg::IRQ_SIX]))
        |=> irq_status[apm_pkg::IRQ_SIX] && (aux_irq_out == irq_enable[apm_pkg::IRQ_SIX] ||
             irq_status[apm_pkg::IRQ_SEVEN]))
        else $error("pin six falling edge missed");

    AST_SGO: assert property (@(posedge clk) disable iff (!rst_n)
        stop_go_bit_output_select |=> aux_pins_oe_n[apm_pkg::PIN_SEVEN] == $past(stop_go_bit))
        else $error("stop/go bit not mirrored on pin seven");

    AST_MODE_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n)
        mode_valid |-> $onehot({terminal_mode, line_terminal_t_mode, line_terminal_s_mode}))
        else $error("mode outputs not one-hot");

    AST_MODE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        mode_valid |=> mode_valid && $stable({line_terminal_t_mode, line_terminal_s_mode}))
        else $error("mode changed after capture");

    AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_fall && wake_reset_enable) |=> wake_status ##0 (!reset_output_oe_n)[*8])
        else $error("wake edge did not flag and reset");

    AST_LED: assert property (@(posedge clk) disable iff (!rst_n)
        (led_auto_select && line_activated) |=> !activation_led_out)
        else $error("activation led not low when active");

    AST_OSC: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(oscillator_clock_out) |-> ##[6:7] $changed(oscillator_clock_out))
        else $error("oscillator clock half period wrong");

    AST_RST_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        (watchdog_timeout || sw_reset_cmd) |=> (!reset_output_oe_n)[*8])
        else $error("reset output pulse too short");

    COV_WAKE: cover property (@(posedge clk) disable iff (!rst_n) wake_fall);
    COV_IRQ: cover property (@(posedge clk) disable iff (!rst_n) $rose(aux_irq_out));
    COV_RST_END: cover property (@(posedge clk) disable iff (!rst_n) $rose(reset_output_oe_n));
    COV_LTS: cover property (@(posedge clk) disable iff (!rst_n) line_terminal_s_mode);

endmodule

//--- tb/apm_board_model.sv
// Board model: pin pull-ups, external pull-downs and the reset net
`timescale 1ns/10ps

// ------------------------------------------------------------
// Board wiring around the auxiliary pins
// ------------------------------------------------------------
module apm_board_model (
    input wire logic [3:0] aux_pins_out,
    input wire logic [3:0] aux_pins_oe_n,
    input wire logic [3:0] pull_low,          // Board parts pulling a pin low
    input wire logic reset_output_out,
    input wire logic reset_output_oe_n,
    output logic [3:0] aux_pins_in,
    output logic reset_line
);
    // Wired-and with pull-up, so a released pin never keeps a stale value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            aux_pins_in[i] = ((!aux_pins_oe_n[i] && !aux_pins_out[i]) || pull_low[i]) ? 1'b0 : 1'b1;
        end
        // Reset net pulled high unless the device sinks it
        reset_line = !reset_output_oe_n ? reset_output_out : 1'b1;
    end
endmodule

//--- tb/apm_aux_mode_test.sv
// Self-checking bench for the auxiliary port and mode pin block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module apm_aux_mode_test;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct {string nm; int sel; logic [7:0] e;} apm_note_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] pin_in, oe_n, pins_out, in_lvl;
    logic [3:0] pull_low = 4'h0, gpio_dir = 4'h0, gpio_val = 4'hF;
    logic mf_sel = 1'b0, mf_out = 1'b1, mf_in, nt = 1'b0, ck_sel = 1'b0, ck_ch = 1'b0;
    logic fs = 1'b0, bc = 1'b1, sg_sel = 1'b0, sg_bit = 1'b1;
    logic [1:0] irq_en = 2'h0, irq_edge = 2'h0, irq_clr = 2'h0, irq_status;
    logic aux_irq, strap1 = 1'b0, strap2 = 1'b1, m_ok, m_t, m_ltt, m_lts;
    logic wake_en = 1'b0, wake_clr = 1'b0, wake_st, led_auto = 1'b0, led_sw = 1'b1;
    logic line_act = 1'b0, led, osc, wdt = 1'b0, swr = 1'b0, rst_out, rst_oe_n, rst_line;
    int bad_count = 0;
    int samples_checked = 0;
    int osc_rises = 0;
    apm_note_t q[$];                          // Expected results awaiting compare
    apm_note_t cur;
    event check_ev;

    // ------------------------------------------------------------
    // Design, board and clock
    // ------------------------------------------------------------
    apm_aux_mode #(.RESET_PULSE_CYCLES(8)) dut (.clk(clk), .rst_n(rst_n), .aux_pins_in(pin_in),
        .aux_pins_out(pins_out), .aux_pins_oe_n(oe_n), .gpio_dir(gpio_dir),
        .gpio_out_val(gpio_val), .gpio_in_level(in_lvl), .multiframe_pin_select(mf_sel),
        .multiframe_bit_out(mf_out), .multiframe_bit_in(mf_in), .network_termination_mode(nt),
        .clock_out_pin_select(ck_sel), .sync_or_bitclock_choice(ck_ch), .frame_sync(fs),
        .bit_clock_out(bc), .stop_go_bit_output_select(sg_sel), .stop_go_bit(sg_bit),
        .irq_enable(irq_en), .irq_edge_mode(irq_edge), .irq_clear(irq_clr),
        .irq_status(irq_status), .aux_irq_out(aux_irq), .first_mode_strap(strap1),
        .second_mode_strap(strap2), .mode_valid(m_ok), .terminal_mode(m_t),
        .line_terminal_t_mode(m_ltt), .line_terminal_s_mode(m_lts), .wake_reset_enable(wake_en),
        .wake_clear(wake_clr), .wake_status(wake_st), .led_auto_select(led_auto),
        .led_sw_value(led_sw), .line_activated(line_act), .activation_led_out(led),
        .oscillator_clock_out(osc), .watchdog_timeout(wdt), .sw_reset_cmd(swr),
        .reset_output_out(rst_out), .reset_output_oe_n(rst_oe_n));
    apm_board_model board (.aux_pins_out(pins_out), .aux_pins_oe_n(oe_n), .pull_low(pull_low),
        .reset_output_out(rst_out), .reset_output_oe_n(rst_oe_n), .aux_pins_in(pin_in),
        .reset_line(rst_line));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // Oscillator output rising edges
    always @(posedge osc) osc_rises++;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Output group picked by a note
    function automatic logic [7:0] obs(input int sel);
        case (sel)
            0: obs = {pins_out, oe_n};
            1: obs = {4'h0, in_lvl};
            2: obs = {4'h0, aux_irq, 1'b0, irq_status};
            3: obs = {4'h0, m_ok, m_t, m_ltt, m_lts};
            4: obs = {5'h0, wake_st, rst_oe_n, rst_line};
            5: obs = {7'h0, mf_in};
            6: obs = {7'h0, led};
            default: obs = {7'h0, (osc_rises >= 76 && osc_rises <= 77)};
        endcase
    endfunction
    // Record an expectation and wake the compare process
    task note(input string nm, input int sel, input logic [7:0] e);
        q.push_back('{nm, sel, e});
        -> check_ev;
    endtask
    // Whole cycles, ending on a falling edge where inputs change
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Reset with given straps, held stable across capture
    task do_reset(input logic s1, input logic s2);
        rst_n = 1'b0;
        strap1 = s1;
        strap2 = s2;
        cyc(2);
        note("reset modes", 3, 8'h00);
        note("reset pins", 0, 8'h0F);
        cyc(10);
        rst_n = 1'b1;
        cyc(12);
    endtask
    task give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Compare process: oldest note first
    // ------------------------------------------------------------
    initial begin
        forever begin
            @(check_ev);
            while (q.size() > 0) begin
                cur = q.pop_front();
                `CHK(cur.nm, cur.e, obs(cur.sel))
            end
        end
    end
    // Hang guard, far beyond the expected run of about 1330 cycles
    initial begin
        #200us;
        bad_count++;
        $display("[ERR] watchdog expected finish seen hang");
        give_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(82691));
        do_reset(1'b1, 1'b0);
        note("mode ltt", 3, 8'h0A);
        do_reset(1'b1, 1'b1);
        note("mode lts", 3, 8'h09);
        do_reset(1'b0, 1'b1);
        note("mode term", 3, 8'h0C);
        $display("test modes done");
        // Random direction, drive and board pulls
        for (int i = 0; i < 12; i++) begin
            gpio_dir = 4'($urandom);
            gpio_val = 4'($urandom);
            pull_low = 4'($urandom);
            cyc(1);
            note("gpio drive", 0, {4'h0, ~(gpio_dir & ~gpio_val)});
            cyc(7);
            note("gpio read", 1, {4'h0, ~(pull_low | (gpio_dir & ~gpio_val))});
        end
        gpio_dir = 4'h0;
        pull_low = 4'h0;
        irq_clr = 2'h3;
        cyc(1);
        irq_clr = 2'h0;
        $display("test gpio done");
        // Alternate roles on pins four, five and seven
        mf_sel = 1'b1;
        mf_out = 1'b0;
        cyc(1);
        note("mf drive", 0, 8'h0E);
        nt = 1'b1;
        pull_low = 4'h1;
        cyc(8);
        note("mf release", 0, 8'h0F);
        note("mf input", 5, 8'h00);
        ck_sel = 1'b1;
        fs = 1'b0;
        cyc(1);
        note("fs out", 0, 8'h0D);
        fs = 1'b1;
        cyc(1);
        note("fs out hi", 0, 8'h0F);
        ck_ch = 1'b1;
        fs = 1'b0;
        cyc(1);
        note("bc out hi", 0, 8'h0F);
        bc = 1'b0;
        fs = 1'b1;
        cyc(1);
        note("bc out lo", 0, 8'h0D);
        ck_sel = 1'b0;
        sg_sel = 1'b1;
        sg_bit = 1'b0;
        cyc(1);
        note("sgo out", 0, 8'h07);
        {mf_sel, nt, sg_sel, pull_low} = {3'h0, 4'h0};
        cyc(8);
        // Synchronised pins are high again: drop level flags left by earlier tests
        irq_clr = 2'h3;
        cyc(1);
        irq_clr = 2'h0;
        $display("test alt roles done");
        // Interrupts on pins six and seven
        for (int p = 0; p < 2; p++) begin
            irq_en = 2'(1 << p);
            irq_edge = 2'h3;
            pull_low = 4'(4 << p);
            cyc(8);
            note("irq edge", 2, {4'h0, 1'b1, 1'b0, 2'(1 << p)});
            pull_low = 4'h0;
            irq_clr = 2'(1 << p);
            cyc(1);
            irq_clr = 2'h0;
            cyc(1);
            note("irq clear", 2, 8'h00);
            irq_edge = 2'h0;
            pull_low = 4'(4 << p);
            cyc(8);
            irq_clr = 2'h3;
            cyc(1);
            irq_clr = 2'h0;
            cyc(1);
            note("irq level", 2, {4'h0, 1'b1, 1'b0, 2'(1 << p)});
            irq_en = 2'h0;
            cyc(1);
            note("irq mask", 2, {6'h0, 2'(1 << p)});
            pull_low = 4'h0;
            cyc(8);
            irq_clr = 2'h3;
            cyc(1);
            irq_clr = 2'h0;
        end
        $display("test irq done");
        // LED in both sources and levels
        for (int i = 0; i < 4; i++) begin
            led_auto = i[1];
            line_act = i[0];
            led_sw = i[0];
            cyc(1);
            note("led", 6, {7'h0, i[1] ? ~i[0] : i[0]});
        end
        osc_rises = 0;
        cyc(1000);
        note("osc rate", 7, 8'h01);
        $display("test led osc done");
        // Reset output from watchdog and from command
        for (int s = 0; s < 2; s++) begin
            {swr, wdt} = 2'(1 << s);
            cyc(1);
            {swr, wdt} = 2'h0;
            cyc(2);
            note("reset low", 4, 8'h00);
            cyc(12);
            note("reset high", 4, 8'h03);
        end
        // Wake falls with and without reset pulse
        wake_en = 1'b1;
        strap2 = 1'b0;
        cyc(8);
        note("wake pulse", 4, 8'h04);
        cyc(14);
        note("wake end", 4, 8'h07);
        wake_clr = 1'b1;
        cyc(1);
        wake_clr = 1'b0;
        cyc(1);
        note("wake clear", 4, 8'h03);
        wake_en = 1'b0;
        strap2 = 1'b1;
        cyc(8);
        strap2 = 1'b0;
        cyc(8);
        note("wake no pulse", 4, 8'h07);
        $display("test reset wake done");
        cyc(4);
        give_verdict();
    end
endmodule
